// ### hdl/tprf_pkg.sv
// Constants shared by the two-port memory with queue logic.
// Assumes a single 25 MHz system clock and an APB register slave.
`default_nettype none
package tprf_pkg;
  localparam int unsigned WORD_W     = 18;
  localparam int unsigned WORDS      = 256;
  localparam int unsigned ADDR_W     = 12;
  localparam int unsigned PTR_W      = 13;
  localparam int unsigned SCAN_BITS  = 4608;
  localparam int unsigned SCAN_WORDS = SCAN_BITS / WORD_W;
  localparam int unsigned SYN_W      = 51;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_AF_THR = 12'h004;
  localparam logic [11:0] OFS_AE_THR = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  // Control field positions
  localparam int unsigned C_FIFO  = 0;
  localparam int unsigned C_PIPE  = 1;
  localparam int unsigned C_ASP   = 2;
  localparam int unsigned C_STOP  = 5;
  localparam int unsigned C_WFALL = 6;
  localparam int unsigned C_RFALL = 7;
  // Status field positions
  localparam int unsigned S_EMPTY = 0;
  localparam int unsigned S_FULL  = 1;
  localparam int unsigned S_AEMP  = 2;
  localparam int unsigned S_AFUL  = 3;
  localparam int unsigned S_BUSY  = 4;
  localparam int unsigned S_LVL   = 16;
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [12:0] AF_RST   = 13'h00F0;
  localparam logic [12:0] AE_RST   = 13'h0010;
  // Aspect codes: depth x width
  localparam logic [2:0] ASP_X1  = 3'h0;
  localparam logic [2:0] ASP_X2  = 3'h1;
  localparam logic [2:0] ASP_X4  = 3'h2;
  localparam logic [2:0] ASP_X9  = 3'h3;
  localparam logic [2:0] ASP_X18 = 3'h4;
endpackage
`default_nettype wire

// ### hdl/tprf_top.sv
// Two-port block memory with optional queue logic, APB configuration,
// serial power-up loading and a two-entry output buffer.
// Assumes port clocks and port signals arrive as pins, asynchronous to
// i_clock and slow enough to be oversampled; i_q_ready is on i_clock.
//
// Local design decisions: the register addresses and register access over APB.
`default_nettype none
// Operation
// [RL1] The array itself writes and reads only on rising internal edges.
// [RL2] Each port has its own clock pin with selectable active edge.
// [RL3] Non-pipelined read: address taken on active edge, word shown after.
// [RL4] Pipe control bit picks non-pipelined or pipelined reads.
// [RL5] Pipelined read passes an output register: one extra edge of latency.
// [RL6] Write edge with write enable high stores data at the address.
// [RL7] Scan port loads all 4608 bits serially in one operation.
// [RL8] Queue organisation selectable: 4096x1 2048x2 1024x4 512x9 256x18.
// [RL9] Queue gives empty, full, almost-empty and almost-full flags.
// [RL10] Empty flag is updated on read port edges.
// [RL11] Full flag is updated on write port edges.
// [RL12] Each almost flag compares fill level against its own threshold.
// [RL13] Reset low, block enable low, write enable low, read enable high.
// [RL14] Option: pointers stop at empty/full, or keep counting past them.
// [RL15] Almost-full at level >= threshold; almost-empty at level <= it.
// [RL16] Queue reset clears pointers and full, sets empty, without clock.
module tprf_top
  import tprf_pkg::*;
(
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [11:0]       i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic      [31:0]       o_prdata,
  output logic                   o_pready,
  output logic                   o_pslverr,
  input  wire logic              i_wr_clk,
  input  wire logic              i_wr_en,
  input  wire logic              i_wr_en_n,
  input  wire logic [ADDR_W-1:0] i_wr_addr,
  input  wire logic [WORD_W-1:0] i_wr_data,
  input  wire logic              i_rd_clk,
  input  wire logic              i_rd_en,
  input  wire logic [ADDR_W-1:0] i_rd_addr,
  output logic      [WORD_W-1:0] o_rd_data,
  input  wire logic              i_blk_en_n,
  input  wire logic              i_fifo_rst_n,
  output logic                   o_empty,
  output logic                   o_full,
  output logic                   o_aempty,
  output logic                   o_afull,
  output logic      [WORD_W-1:0] o_q_data,
  output logic                   o_q_valid,
  input  wire logic              i_q_ready,
  input  wire logic              i_scan_sel,
  input  wire logic              i_scan_shift,
  input  wire logic              i_scan_data
);

  logic [WORD_W-1:0] mem [WORDS];
  logic [SYN_W-1:0]  meta;
  logic [SYN_W-1:0]  syn;
  logic [7:0]        ctrl;
  logic [12:0]       af_thr;
  logic [12:0]       ae_thr;
  logic              wr_prev;
  logic              rd_prev;
  logic              sh_prev;
  logic              sel_prev;
  logic              rst_meta;
  logic              fifo_rst_n;
  logic [PTR_W-1:0]  wptr;
  logic [PTR_W-1:0]  rptr;
  logic [WORD_W-1:0] stage;
  logic [WORD_W-1:0] sr;
  logic [4:0]        bitc;
  logic [8:0]        scan_word;
  logic [WORD_W-1:0] q_e1;
  logic [1:0]        q_cnt;

  // Word index of a linear address for the selected organisation
  function automatic logic [7:0] word_of(input logic [11:0] a,
                                         input logic [2:0] s);
    unique case (s)
      ASP_X1:  word_of = a[11:4];
      ASP_X2:  word_of = a[10:3];
      ASP_X4:  word_of = a[9:2];
      ASP_X9:  word_of = a[8:1];
      default: word_of = a[7:0];
    endcase
  endfunction

  // Bit offset of the lane inside the 18-bit word
  function automatic logic [4:0] lane_of(input logic [11:0] a,
                                         input logic [2:0] s);
    unique case (s)
      ASP_X1:  lane_of = {1'h0, a[3:0]};
      ASP_X2:  lane_of = {1'h0, a[2:0], 1'h0};
      ASP_X4:  lane_of = {1'h0, a[1:0], 2'h0};
      ASP_X9:  lane_of = a[0] ? 5'h09 : 5'h00;
      default: lane_of = 5'h00;
    endcase
  endfunction

  // Width mask and depth; illegal codes fall back to 256x18
  function automatic logic [WORD_W-1:0] mask_of(input logic [2:0] s);
    unique case (s)
      ASP_X1:  mask_of = 18'h00001;
      ASP_X2:  mask_of = 18'h00003;
      ASP_X4:  mask_of = 18'h0000F;
      ASP_X9:  mask_of = 18'h001FF;
      default: mask_of = 18'h3FFFF;
    endcase
  endfunction

  function automatic logic [PTR_W-1:0] depth_of(input logic [2:0] s);
    unique case (s)
      ASP_X1:  depth_of = 13'h1000;
      ASP_X2:  depth_of = 13'h0800;
      ASP_X4:  depth_of = 13'h0400;
      ASP_X9:  depth_of = 13'h0200;
      default: depth_of = 13'h0100;
    endcase
  endfunction

  // Pin sampling; all pins share one delay so data stays aligned to clocks
  always_ff @(posedge i_clock) begin
    meta <= {i_wr_clk, i_wr_en, i_wr_en_n, i_wr_addr, i_wr_data,
             i_rd_clk, i_rd_en, i_rd_addr, i_blk_en_n,
             i_scan_sel, i_scan_shift, i_scan_data};
    syn  <= meta;
  end

  wire              s_wr_clk;
  wire              s_wr_en;
  wire              s_wr_en_n;
  wire [ADDR_W-1:0] s_wr_addr;
  wire [WORD_W-1:0] s_wr_data;
  wire              s_rd_clk;
  wire              s_rd_en;
  wire [ADDR_W-1:0] s_rd_addr;
  wire              s_blk_n;
  wire              s_sel;
  wire              s_shift;
  wire              s_sdata;
  assign {s_wr_clk, s_wr_en, s_wr_en_n, s_wr_addr, s_wr_data,
          s_rd_clk, s_rd_en, s_rd_addr, s_blk_n,
          s_sel, s_shift, s_sdata} = syn;

  // Configuration fields
  wire       fifo_mode = ctrl[C_FIFO];
  wire       pipe      = ctrl[C_PIPE];
  wire [2:0] asp       = ctrl[C_ASP +: 3];
  wire       stop      = ctrl[C_STOP];

  // Falling-edge ports invert their clock, so only rising edges are seen.
  // The history holds the raw pin, so flipping the edge select makes no
  // false edge.
  wire wr_lvl = s_wr_clk ^ ctrl[C_WFALL]; // RL2
  wire rd_lvl = s_rd_clk ^ ctrl[C_RFALL]; // RL2
  wire wr_ev  = wr_lvl & (s_wr_clk ^ wr_prev); // RL1
  wire rd_ev  = rd_lvl & (s_rd_clk ^ rd_prev); // RL1
  wire sh_ev  = s_shift & ~sh_prev;
  wire sel_ev = s_sel & ~sel_prev;

  always_ff @(posedge i_clock) begin
    wr_prev  <= s_wr_clk;
    rd_prev  <= s_rd_clk;
    sh_prev  <= s_shift;
    sel_prev <= s_sel;
  end

  // Queue fill level and request qualification
  wire [PTR_W-1:0] depth   = depth_of(asp);
  wire [PTR_W-1:0] lvl     = PTR_W'(wptr - rptr);
  wire             is_full = lvl >= depth;
  wire             is_emp  = lvl == 13'h0000;
  wire             q_room  = q_cnt != 2'h2;
  wire push_req = wr_ev & fifo_mode & ~s_wr_en_n & ~s_blk_n & ~s_sel; // RL13
  wire pop_req  = rd_ev & fifo_mode & s_rd_en & ~s_blk_n; // RL13
  wire push     = push_req & ~(stop & is_full); // RL14
  wire pop      = pop_req & q_room & ~(stop & is_emp); // RL14
  wire [PTR_W-1:0] next_wptr = push ? PTR_W'(wptr + 13'h0001) : wptr;
  wire [PTR_W-1:0] next_rptr = pop ? PTR_W'(rptr + 13'h0001) : rptr;
  wire [PTR_W-1:0] next_lvl  = PTR_W'(next_wptr - next_rptr);

  // Address mapping for both ports under the chosen organisation
  wire [ADDR_W-1:0] wa     = fifo_mode ? wptr[ADDR_W-1:0] : s_wr_addr;
  wire [ADDR_W-1:0] ra     = fifo_mode ? rptr[ADDR_W-1:0] : s_rd_addr;
  wire [7:0]        wword  = word_of(wa, asp); // RL8
  wire [4:0]        wsh    = lane_of(wa, asp); // RL8
  wire [WORD_W-1:0] wmask  = mask_of(asp);
  wire [WORD_W-1:0] wm     = WORD_W'(wmask << wsh);
  wire [WORD_W-1:0] wd     = WORD_W'((s_wr_data & wmask) << wsh);
  wire [7:0]        rword  = word_of(ra, asp);
  wire [4:0]        rsh    = lane_of(ra, asp);
  wire [WORD_W-1:0] rd_word = WORD_W'(mem[rword] >> rsh) & wmask;
  wire ram_we  = wr_ev & ~fifo_mode & s_wr_en & ~s_sel; // RL6
  wire ram_re  = rd_ev & ~fifo_mode & s_rd_en;
  wire user_we = ram_we | push;
  wire [WORD_W-1:0] next_wline = (mem[wword] & ~wm) | (wd & wm);

  // Scan load: bits arrive lowest first, a word is stored every 18 bits
  wire [WORD_W-1:0] scan_val = {s_sdata, sr[WORD_W-1:1]};
  wire scan_we = sh_ev & s_sel & (bitc == 5'h11) &
                 (scan_word < 9'(SCAN_WORDS)); // RL7

  always_ff @(posedge i_clock) begin
    if (i_rst || sel_ev) begin
      sr        <= 18'h00000;
      bitc      <= 5'h00;
      scan_word <= 9'h000;
    end else if (sh_ev && s_sel) begin
      sr   <= scan_val; // RL7
      bitc <= (bitc == 5'h11) ? 5'h00 : 5'(bitc + 5'h01);
      if (scan_we) begin
        scan_word <= 9'(scan_word + 9'h001);
      end
    end
  end

  // Array port; scan loading wins, user writes are blocked while selected
  always_ff @(posedge i_clock) begin
    if (scan_we) begin
      mem[scan_word[7:0]] <= scan_val; // RL7
    end else if (user_we) begin
      mem[wword] <= next_wline; // RL6
    end
  end

  // Read register; in memory mode the output register loads on every active read edge when pipelined, else only on enabled reads
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      stage     <= 18'h00000;
      o_rd_data <= 18'h00000;
    end else if (rd_ev && !fifo_mode) begin
      if (ram_re) begin
        stage <= rd_word; // RL3
      end
      if (pipe) begin
        o_rd_data <= stage; // RL5
      end else if (ram_re) begin
        o_rd_data <= rd_word; // RL4
      end
    end
  end

  // Queue reset: asserts at once, releases on the clock
  always_ff @(posedge i_clock or negedge i_fifo_rst_n) begin
    if (!i_fifo_rst_n) begin
      rst_meta   <= 1'h0;
      fifo_rst_n <= 1'h0;
    end else begin
      rst_meta   <= 1'h1;
      fifo_rst_n <= rst_meta;
    end
  end

  // Pointers and flags; empty side follows read edges, full side writes
  always_ff @(posedge i_clock or negedge fifo_rst_n) begin
    if (!fifo_rst_n) begin
      wptr     <= 13'h0000; // RL16
      rptr     <= 13'h0000;
      o_empty  <= 1'h1;
      o_full   <= 1'h0;
      o_aempty <= 1'h1;
      o_afull  <= 1'h0;
    end else if (i_rst) begin
      wptr     <= 13'h0000;
      rptr     <= 13'h0000;
      o_empty  <= 1'h1; // RL9
      o_full   <= 1'h0;
      o_aempty <= 1'h1;
      o_afull  <= 1'h0;
    end else begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      if (rd_ev) begin
        o_empty  <= next_lvl == 13'h0000; // RL10
        o_aempty <= next_lvl <= ae_thr; // RL15
      end
      if (wr_ev) begin
        o_full  <= next_lvl >= depth; // RL11
        o_afull <= next_lvl >= af_thr; // RL12
      end
    end
  end

  // Two-entry output buffer; a full buffer stalls pops upstream
  wire q_take = o_q_valid & i_q_ready;
  always_ff @(posedge i_clock) begin
    if (i_rst || !fifo_rst_n) begin
      q_cnt     <= 2'h0;
      o_q_valid <= 1'h0;
      o_q_data  <= 18'h00000;
      q_e1      <= 18'h00000;
    end else begin
      q_cnt     <= 2'(q_cnt + {1'h0, pop} - {1'h0, q_take});
      o_q_valid <= 2'(q_cnt + {1'h0, pop} - {1'h0, q_take}) != 2'h0;
      if (q_take) begin
        o_q_data <= (q_cnt == 2'h2) ? q_e1 : rd_word;
      end else if (pop && q_cnt == 2'h0) begin
        o_q_data <= rd_word;
      end
      if (pop && (q_cnt == 2'h2 || (q_cnt == 2'h1 && !q_take))) begin
        q_e1 <= rd_word;
      end
    end
  end

  // APB slave: one wait state, registered answer, error on unmapped
  wire apb_acc  = i_psel & i_penable & ~o_pready;
  wire apb_done = i_psel & i_penable & o_pready;
  wire hit_ctrl = i_paddr == OFS_CTRL;
  wire hit_af   = i_paddr == OFS_AF_THR;
  wire hit_ae   = i_paddr == OFS_AE_THR;
  wire hit_st   = i_paddr == OFS_STATUS;
  wire hit      = hit_ctrl | hit_af | hit_ae | hit_st;
  wire [31:0] st_word = {3'h0, lvl, 11'h000, s_sel, o_afull, o_aempty,
                         o_full, o_empty};
  wire [31:0] rdata = hit_ctrl ? {24'h000000, ctrl} :
                      hit_af   ? {19'h00000, af_thr} :
                      hit_ae   ? {19'h00000, ae_thr} :
                      hit_st   ? st_word : 32'h00000000;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_pready  <= 1'h0;
      o_pslverr <= 1'h0;
      o_prdata  <= 32'h00000000;
      ctrl      <= CTRL_RST;
      af_thr    <= AF_RST;
      ae_thr    <= AE_RST;
    end else begin
      o_pready  <= apb_acc;
      o_pslverr <= apb_acc & ~hit;
      o_prdata  <= (apb_acc && !i_pwrite) ? rdata : 32'h00000000;
      if (apb_done && i_pwrite && !o_pslverr) begin
        if (hit_ctrl) ctrl <= i_pwdata[7:0]; // RL4
        if (hit_af) af_thr <= i_pwdata[12:0];
        if (hit_ae) ae_thr <= i_pwdata[12:0];
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst || !fifo_rst_n);

  empty_track_a: assert property (rd_ev |=> o_empty == (lvl == 0)) // RL10
    else $error("empty flag wrong after read edge");
  full_track_a: assert property (wr_ev |=> o_full == (lvl >= depth)) // RL11
    else $error("full flag wrong after write edge");
  afull_level_a: assert property (wr_ev |=> o_afull == (lvl >= af_thr)) // RL15
    else $error("almost-full flag wrong");
  aempty_level_a: assert property (rd_ev |=> o_aempty == (lvl <= ae_thr)) // RL12
    else $error("almost-empty flag wrong");
  stop_full_a: assert property (stop && push_req && is_full |=> $stable(wptr)) // RL14
    else $error("write pointer moved past full");
  blk_off_a: assert property (s_blk_n |=> $stable(wptr) && $stable(rptr)) // RL13
    else $error("pointer moved while block disabled");
  direct_read_a: assert property (ram_re && !pipe |=> o_rd_data == $past(rd_word)) // RL3
    else $error("non-pipelined read data wrong");
  pipe_read_a: assert property (rd_ev && !fifo_mode && pipe |=> o_rd_data == $past(stage)) // RL5
    else $error("pipelined read data wrong");
  rd_hold_a: assert property (!(rd_ev && !fifo_mode) |=> $stable(o_rd_data)) // RL2
    else $error("read data changed without active edge");
  ram_write_a: assert property (ram_we |=> (18'(mem[$past(wword)] >> $past(wsh)) & $past(wmask)) == $past(s_wr_data & wmask)) // RL6
    else $error("written word not stored");
  scan_store_a: assert property (scan_we |=> mem[$past(scan_word[7:0])] == $past(scan_val)) // RL7
    else $error("scan word not stored");
  q_hold_a: assert property (o_q_valid && !i_q_ready |=> o_q_valid && $stable(o_q_data))
    else $error("buffer head lost while stalled");
  fifo_reset_a: assert property (@(posedge i_clock) disable iff (i_rst) !fifo_rst_n |-> o_empty && !o_full && wptr == 0 && rptr == 0) // RL16
    else $error("queue reset state wrong");
  apb_wait_a: assert property (@(posedge i_clock) disable iff (i_rst) apb_acc |=> o_pready)
    else $error("APB answer late");

endmodule
`default_nettype wire

// ### sim/tprf_fabric.sv
// User fabric model on the far side of the memory ports and scan pins.
// Assumes the 25 MHz system clock; pins move just after its rising edge
// and stay put four cycles around each port clock edge.
`default_nettype none
module tprf_fabric
  import tprf_pkg::*;
(
  input  wire logic              i_clock,
  output var  logic              o_wr_clk,
  output var  logic              o_wr_en,
  output var  logic              o_wr_en_n,
  output var  logic [ADDR_W-1:0] o_wr_addr,
  output var  logic [WORD_W-1:0] o_wr_data,
  output var  logic              o_rd_clk,
  output var  logic              o_rd_en,
  output var  logic [ADDR_W-1:0] o_rd_addr,
  output var  logic              o_scan_sel,
  output var  logic              o_scan_shift,
  output var  logic              o_scan_data
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle levels; port clocks stand still between transfers
  initial begin
    {o_wr_clk, o_wr_en, o_rd_clk, o_rd_en} = 4'h0;
    o_wr_en_n = 1'b1;
    {o_wr_addr, o_rd_addr} = 24'h000000;
    o_wr_data = 18'h00000;
    {o_scan_sel, o_scan_shift, o_scan_data} = 3'h0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  // One write pulse; data may change between edges to show which one took
  task automatic wr(input logic q, input logic [ADDR_W-1:0] a,
                    input logic [WORD_W-1:0] d0, input logic [WORD_W-1:0] d1);
    @(posedge i_clock);
    o_wr_addr <= a;
    o_wr_data <= d0;
    o_wr_en   <= ~q;
    o_wr_en_n <= ~q;
    hold(4);
    o_wr_clk <= 1'b1;
    hold(4);
    o_wr_data <= d1;
    hold(4);
    o_wr_clk <= 1'b0;
    hold(4);
    o_wr_en   <= 1'b0;
    o_wr_en_n <= 1'b1;
    o_wr_addr <= ~a;  // Released lines show the inverse, never a stale word
    o_wr_data <= ~d1;
  endtask

  // One read pulse with read enable high
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge i_clock);
    o_rd_addr <= a;
    o_rd_en   <= 1'b1;
    hold(4);
    o_rd_clk <= 1'b1;
    hold(8);
    o_rd_clk <= 1'b0;
    hold(4);
    o_rd_en   <= 1'b0;
    o_rd_addr <= ~a;
  endtask

  // Scan select and one serial bit on a rising shift edge
  task automatic select(input logic v);
    @(posedge i_clock);
    o_scan_sel  <= v;
    o_scan_data <= ~o_scan_data;
  endtask

  task automatic shift(input logic b);
    @(posedge i_clock);
    o_scan_data <= b;
    hold(3);
    o_scan_shift <= 1'b1;
    hold(3);
    o_scan_shift <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### sim/two_port_ram_with_fifo_bench.sv
// Self-checking bench for the two-port memory with queue logic.
// Assumes the fabric model drives the ports; APB master lives here.
`default_nettype none
module two_port_ram_with_fifo_bench
  import tprf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [11:0] a; logic [31:0] d; logic e;} tprf_row_t;
  typedef struct {logic [2:0] c; logic [17:0] m;} tprf_asp_t;
  localparam logic [31:0] X18 = 32'(ASP_X18) << C_ASP;
  localparam logic [31:0] ST0 = (32'h1 << S_EMPTY) | (32'h1 << S_AEMP);
  tprf_row_t rows [5] = '{'{OFS_CTRL, {24'h000000, CTRL_RST}, 1'b0},
    '{OFS_AF_THR, {19'h00000, AF_RST}, 1'b0},
    '{OFS_AE_THR, {19'h00000, AE_RST}, 1'b0},
    '{OFS_STATUS, ST0, 1'b0}, '{12'h010, 32'h0, 1'b1}};
  tprf_asp_t asp [5] = '{'{ASP_X1, 18'h00001}, '{ASP_X2, 18'h00003},
    '{ASP_X4, 18'h0000F}, '{ASP_X9, 18'h001FF}, '{ASP_X18, 18'h3FFFF}};
  logic              clk = 1'b0;
  logic              rst, psel, penable, pwrite, blk_en_n, fifo_rst_n;
  logic              q_ready;
  logic [11:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata, rv;
  logic              pready, pslverr, er, wr_clk, wr_en, wr_en_n, rd_clk;
  logic              rd_en, scan_sel, scan_shift, scan_data;
  logic              empty, full, aempty, afull, q_valid;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [WORD_W-1:0] wr_data, rd_data, q_data, sw;
  logic [17:0]       expq [$];
  int                errors = 0;
  int                checked = 0;
  int                cycles = 0;

  tprf_top u_tprf_top (.i_clock(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_wr_clk(wr_clk), .i_wr_en(wr_en),
    .i_wr_en_n(wr_en_n), .i_wr_addr(wr_addr), .i_wr_data(wr_data),
    .i_rd_clk(rd_clk), .i_rd_en(rd_en), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data), .i_blk_en_n(blk_en_n), .i_fifo_rst_n(fifo_rst_n),
    .o_empty(empty), .o_full(full), .o_aempty(aempty), .o_afull(afull),
    .o_q_data(q_data), .o_q_valid(q_valid), .i_q_ready(q_ready),
    .i_scan_sel(scan_sel), .i_scan_shift(scan_shift),
    .i_scan_data(scan_data));
  tprf_fabric u_tprf_fabric (.i_clock(clk), .o_wr_clk(wr_clk),
    .o_wr_en(wr_en), .o_wr_en_n(wr_en_n), .o_wr_addr(wr_addr),
    .o_wr_data(wr_data), .o_rd_clk(rd_clk), .o_rd_en(rd_en),
    .o_rd_addr(rd_addr), .o_scan_sel(scan_sel), .o_scan_shift(scan_shift),
    .o_scan_data(scan_data));

  always #20 clk = ~clk;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // A hang ends as a mismatch; the run needs about 42000 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 70000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic check(input string n, input logic [31:0] got, exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask

  // One APB transfer; held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic qreset();
    @(posedge clk);
    fifo_rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    fifo_rst_n <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  function automatic logic [17:0] scan_word(input int w);
    return (w > 255) ? 18'h3FFFF : {~8'(w), 2'h1, 8'(w)};
  endfunction

  // Consumer scoreboard: each accepted word must be the oldest expected
  always @(posedge clk) begin
    if (q_valid === 1'b1 && q_ready === 1'b1) begin
      if (expq.size() == 0) check("q_extra", 32'h1, 32'h0);
      else check("q_data", q_data, expq.pop_front());
    end
  end

  initial begin
    rst        = 1'b1;
    psel       = 1'b0;
    penable    = 1'b0;
    pwrite     = 1'b0;
    paddr      = 12'h000;
    pwdata     = 32'h00000000;
    blk_en_n   = 1'b1;
    fifo_rst_n = 1'b1;
    q_ready    = 1'b0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (rows[k]) begin
      apb(1'b0, rows[k].a, 32'h0);
      check("prdata", rv, rows[k].d);
      check("pslverr", er, rows[k].e);
    end
    apb(1'b1, OFS_STATUS, 32'hFFFFFFFF);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("status_ro", rv, ST0);
    // Serial load of the whole array, one surplus word must be ignored
    apb(1'b1, OFS_CTRL, X18);
    u_tprf_fabric.select(1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    check("scan_sel", rv[S_BUSY], 32'h1);
    for (int w = 0; w < 257; w++) begin
      sw = scan_word(w);
      for (int b = 0; b < 18; b++) u_tprf_fabric.shift(sw[b]);
    end
    u_tprf_fabric.select(1'b0);
    foreach (asp[k]) begin
      u_tprf_fabric.rd(12'(k * 60));
      check("scan_word", rd_data, scan_word(k * 60));
    end
    // Edge choice and read modes of the plain memory
    u_tprf_fabric.wr(1'b0, 12'h003, 18'h0A5A5, 18'h15A5A);
    u_tprf_fabric.rd(12'h003);
    check("rd_rise", rd_data, 32'h0A5A5);
    apb(1'b1, OFS_CTRL, X18 | (32'h1 << C_WFALL));
    u_tprf_fabric.wr(1'b0, 12'h004, 18'h0A5A5, 18'h15A5A);
    u_tprf_fabric.rd(12'h004);
    check("rd_fall", rd_data, 32'h15A5A);
    apb(1'b1, OFS_CTRL, X18 | (32'h1 << C_PIPE));
    u_tprf_fabric.rd(12'h003);
    check("pipe_1", rd_data, 32'h15A5A);
    u_tprf_fabric.rd(12'h004);
    check("pipe_2", rd_data, 32'h0A5A5);
    // Queue filled to refusal in stop mode, then drained until a read at empty is refused
    qreset();
    apb(1'b1, OFS_CTRL, 32'h1 | X18 | (32'h1 << C_STOP));
    apb(1'b1, OFS_AF_THR, 32'h3);
    apb(1'b1, OFS_AE_THR, 32'h1);
    u_tprf_fabric.wr(1'b1, 12'h000, 18'h3FFFF, 18'h3FFFF);
    blk_en_n <= 1'b0;
    for (int i = 0; i < 257; i++) begin
      u_tprf_fabric.wr(1'b1, 12'h000, 18'(i), 18'(i));
      if (i < 256) expq.push_back(18'(i));
      if (i == 1 || i == 2) check("afull", afull, 32'(i == 2));
      if (i > 253 && i < 256) check("full", full, 32'(i == 255));
    end
    apb(1'b0, OFS_STATUS, 32'h0);
    check("level", rv[S_LVL +: 13], 32'h100);
    repeat (3) u_tprf_fabric.rd(12'h000);
    check("q_valid", q_valid, 32'h1);
    check("empty", empty, 32'h0);
    check("aempty", aempty, 32'h0);
    q_ready <= 1'b1;
    repeat (255) u_tprf_fabric.rd(12'h000);
    check("empty", empty, 32'h1);
    check("aempty", aempty, 32'h1);
    check("q_left", 32'(expq.size()), 32'h0);
    // Queue reset acts before any clock edge
    apb(1'b1, OFS_CTRL, 32'h1 | X18);
    q_ready <= 1'b0;
    repeat (2) u_tprf_fabric.wr(1'b1, 12'h000, 18'h00155, 18'h00155);
    u_tprf_fabric.rd(12'h000);
    check("empty", empty, 32'h0);
    @(posedge clk);
    fifo_rst_n <= 1'b0;
    #5;
    check("rst_flags", {empty, full}, 32'h2);
    // The output buffer clears on the clock, after the flags
    repeat (2) @(posedge clk);
    check("rst_q", q_valid, 32'h0);
    qreset();
    // Every organisation passes one word at its own width
    q_ready <= 1'b1;
    foreach (asp[k]) begin
      qreset();
      apb(1'b1, OFS_CTRL, 32'h1 | (32'(asp[k].c) << C_ASP));
      expq.push_back(18'h2B5A7 & asp[k].m);
      u_tprf_fabric.wr(1'b1, 12'h000, 18'h2B5A7, 18'h2B5A7);
      u_tprf_fabric.rd(12'h000);
      check("q_left", 32'(expq.size()), 32'h0);
    end
    wrap_up();
  end
endmodule
`default_nettype wire
